/* src/epi_pkg.sv */
package epi_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] EPI_OFS_CTRL = 8'h00;
  localparam logic [7:0] EPI_OFS_STAT = 8'h04;
  localparam logic [7:0] EPI_OFS_MASK = 8'h08;
  // Bus widths
  localparam int EPI_AW = 8;
  localparam int EPI_DW = 32;
  // Control and status field positions
  localparam int EPI_BIT_MODE = 0;
  localparam int EPI_BIT_IE = 1;
  localparam int EPI_BIT_ACK = 2;
  localparam int EPI_BIT_FLAG = 3;
  localparam int EPI_BIT_PE = 4;
  localparam int EPI_BIT_POL = 5;
  localparam int EPI_BIT_PDD = 6;
  // Sticky event bits of the status and mask registers
  localparam int EPI_EV_SET = 0;
  localparam int EPI_EV_CLR = 1;
  localparam int EPI_EV_W = 2;
  // Values after reset
  localparam logic [7:0] EPI_CTRL_RST = 8'h00;
  localparam logic [EPI_EV_W-1:0] EPI_EV_RST = 2'h0;
  localparam logic [EPI_DW-1:0] EPI_RDATA_RST = 32'h0000_0000;
  // Stages of the pin synchroniser
  localparam int EPI_SYNC_STAGES = 2;
  // Bus handshake states
  typedef enum logic [0:0] {
    EPI_BUS_IDLE = 1'b0,
    EPI_BUS_DONE = 1'b1
  } epi_bus_t;
endpackage

/* src/epi_sync.sv */
`timescale 1ns/10ps
// Two-stage level synchroniser; first stage feeds only the second
module epi_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  import epi_pkg::*;

  logic [EPI_SYNC_STAGES-1:0] stage; // Shift chain

  // Shift the raw level through the chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= '0;
    end else begin
      stage <= {stage[EPI_SYNC_STAGES-2:0], din};
    end
  end

  // Last stage is the safe copy
  always_comb begin
    dout = stage[EPI_SYNC_STAGES-1];
  end
endmodule // epi_sync

/* src/epi_top.sv */
`timescale 1ns/10ps
// Operation
// - Bit 4 enables pin interrupt function
// - Bit 5 picks falling or rising polarity
// - Pull-down for rising, pull-up for falling
// - Bit 6 disables the internal pull device
// - Bit 0: edges only, or edges plus levels
// - Bit 3 flag set on qualifying event
// - Writing 1 to bit 2 clears flag
// - Acknowledge write 0 ignored, reads 0
// - Level mode keeps flag while pin asserted
// - CPU request when flag and bit 1 set
module epi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [epi_pkg::EPI_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [epi_pkg::EPI_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [epi_pkg::EPI_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_in,
  output logic pin_req_enable,
  output logic pin_pull_up_en,
  output logic pin_pull_down_en,
  output logic cpu_irq,
  output logic irq
);
  import epi_pkg::*;

  // Control fields
  logic detect_mode_select; // Edge only or edge plus level
  logic pin_interrupt_enable; // CPU request enable
  logic pin_function_enable; // Pin acts as request input
  logic polarity_select; // Rising when set
  logic pull_device_disable; // Pull device off when set
  logic pin_event_flag; // Pending request flag

  // Pin sampling
  logic pin_sync; // Synchronised pin level
  logic pin_prev; // Previous synchronised sample
  logic level_active; // Pin at its asserted level
  logic prev_active; // Previous sample at asserted level
  logic edge_hit; // Edge of selected polarity
  logic set_event; // Qualifying request event

  // Bus decode
  epi_bus_t bus_state; // Handshake phase
  logic access; // Access phase, answer not yet given
  logic done; // Completing edge of a transfer
  logic hit_ctrl; // Control register selected
  logic hit_stat; // Status register selected
  logic hit_mask; // Mask register selected
  logic mapped; // Any register selected
  logic wr_lane0; // Write with low byte enabled
  logic wr_ctrl; // Completed control write
  logic wr_ack; // Acknowledge written as one
  logic wr_mask; // Completed mask write

  // Interrupt bookkeeping
  logic [EPI_EV_W-1:0] ev_status; // Sticky events
  logic [EPI_EV_W-1:0] ev_mask; // Event mask
  logic [EPI_EV_W-1:0] ev_pulse; // Events this cycle
  logic [EPI_EV_W-1:0] stat_taken; // Status bits handed to a read
  logic [7:0] ctrl_view; // Control register as read
  logic [EPI_DW-1:0] next_rdata; // Read data for the selected register

  // Pin synchroniser instance
  epi_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pin_in),
    .dout(pin_sync)
  );

  // Previous sample for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  // Asserted level follows polarity, edge from sample pair
  always_comb begin
    level_active = polarity_select ? pin_sync : !pin_sync;
    prev_active = polarity_select ? pin_prev : !pin_prev;
    edge_hit = level_active && !prev_active;
    // Only an enabled pin raises events
    set_event = pin_function_enable
                && (edge_hit || (detect_mode_select && level_active));
  end

  // Bus phase decode
  always_comb begin
    access = psel && penable && (bus_state == EPI_BUS_IDLE);
    done = psel && penable && pready;
    hit_ctrl = (paddr == EPI_OFS_CTRL);
    hit_stat = (paddr == EPI_OFS_STAT);
    hit_mask = (paddr == EPI_OFS_MASK);
    mapped = hit_ctrl || hit_stat || hit_mask;
    wr_lane0 = done && pwrite && pstrb[0];
    wr_ctrl = wr_lane0 && hit_ctrl;
    wr_mask = wr_lane0 && hit_mask;
    wr_ack = wr_ctrl && pwdata[EPI_BIT_ACK];
  end

  // One wait state: answer on the cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= EPI_BUS_IDLE;
    end else begin
      unique case (bus_state)
        EPI_BUS_IDLE: begin
          // Access seen, answer next
          if (access) begin
            bus_state <= EPI_BUS_DONE;
          end
        end
        EPI_BUS_DONE: begin
          // Answer given, back to idle
          bus_state <= EPI_BUS_IDLE;
        end
      endcase
    end
  end

  // Ready and error strobes from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
    end
  end

  // Control register view; ack and unused bit read zero
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[EPI_BIT_MODE] = detect_mode_select;
    ctrl_view[EPI_BIT_IE] = pin_interrupt_enable;
    ctrl_view[EPI_BIT_FLAG] = pin_event_flag;
    ctrl_view[EPI_BIT_PE] = pin_function_enable;
    ctrl_view[EPI_BIT_POL] = polarity_select;
    ctrl_view[EPI_BIT_PDD] = pull_device_disable;
  end

  // Read multiplexer
  always_comb begin
    next_rdata = EPI_RDATA_RST;
    if (hit_ctrl) begin
      next_rdata[7:0] = ctrl_view;
    end else if (hit_stat) begin
      next_rdata[EPI_EV_W-1:0] = ev_status;
    end else if (hit_mask) begin
      next_rdata[EPI_EV_W-1:0] = ev_mask;
    end
  end

  // Read data captured as the answer is prepared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= EPI_RDATA_RST;
      stat_taken <= EPI_EV_RST;
    end else if (access && !pwrite) begin
      prdata <= next_rdata;
      stat_taken <= hit_stat ? ev_status : EPI_EV_RST;
    end else if (done) begin
      stat_taken <= EPI_EV_RST;
    end
  end

  // Control fields written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_mode_select <= 1'b0;
      pin_interrupt_enable <= 1'b0;
      pin_function_enable <= 1'b0;
      polarity_select <= 1'b0;
      pull_device_disable <= 1'b0;
    end else if (wr_ctrl) begin
      detect_mode_select <= pwdata[EPI_BIT_MODE];
      pin_interrupt_enable <= pwdata[EPI_BIT_IE];
      pin_function_enable <= pwdata[EPI_BIT_PE];
      polarity_select <= pwdata[EPI_BIT_POL];
      pull_device_disable <= pwdata[EPI_BIT_PDD];
    end
  end

  // Event flag: a new event wins over an acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_event_flag <= 1'b0;
    end else if (set_event) begin
      pin_event_flag <= 1'b1;
    end else if (wr_ack) begin
      pin_event_flag <= 1'b0;
    end
  end

  // Pull device direction and pin function outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_req_enable <= 1'b0;
      pin_pull_up_en <= 1'b0;
      pin_pull_down_en <= 1'b0;
    end else begin
      pin_req_enable <= pin_function_enable;
      // Pull only while enabled and not disabled
      pin_pull_up_en <= pin_function_enable && !pull_device_disable
                        && !polarity_select;
      pin_pull_down_en <= pin_function_enable && !pull_device_disable
                          && polarity_select;
    end
  end

  // CPU request follows flag and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= pin_event_flag && pin_interrupt_enable;
    end
  end

  // Event pulses for the sticky status
  always_comb begin
    ev_pulse = EPI_EV_RST;
    ev_pulse[EPI_EV_SET] = set_event && !pin_event_flag;
    ev_pulse[EPI_EV_CLR] = wr_ack && !set_event && pin_event_flag;
  end

  // Sticky status: read clears only bits handed out, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status <= EPI_EV_RST;
    end else begin
      if (done && !pwrite && hit_stat) begin
        ev_status <= (ev_status & ~stat_taken) | ev_pulse;
      end else begin
        ev_status <= ev_status | ev_pulse;
      end
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_mask <= EPI_EV_RST;
    end else if (wr_mask) begin
      ev_mask <= pwdata[EPI_EV_W-1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_status & ev_mask);
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Disabled pin never raises a new flag
  chk_pin_disabled_quiet: assert property (
    (!pin_function_enable && !pin_event_flag) |=> !pin_event_flag)
    else $error("flag set while pin function disabled");

  // Falling polarity sees a falling synchronised edge
  chk_falling_edge_flag: assert property (
    (pin_function_enable && !polarity_select && !pin_sync && pin_prev)
    |=> pin_event_flag)
    else $error("falling edge did not set flag");

  // Rising polarity pulls down, not up
  chk_pull_direction: assert property (
    (pin_function_enable && !pull_device_disable && polarity_select
     && !wr_ctrl) |=> (pin_pull_down_en && !pin_pull_up_en))
    else $error("pull direction wrong for rising polarity");

  // Disabled pull device drives neither pull
  chk_pull_disable: assert property (
    (pin_function_enable && pull_device_disable && !wr_ctrl)
    |=> (!pin_pull_up_en && !pin_pull_down_en))
    else $error("pull active while disabled");

  // Edge mode ignores a held level after acknowledge
  chk_edge_only_mode: assert property (
    (!detect_mode_select && !edge_hit && wr_ack) |=> !pin_event_flag)
    else $error("edge mode kept flag on level");

  // Qualifying edge sets flag next cycle
  chk_edge_sets_flag: assert property (
    (pin_function_enable && edge_hit) |=> pin_event_flag)
    else $error("edge did not set flag");

  // Acknowledge without new event clears flag
  chk_ack_clears: assert property (
    (wr_ack && !set_event) |=> !pin_event_flag)
    else $error("acknowledge did not clear flag");

  // Acknowledge bit reads zero
  chk_ack_reads_zero: assert property (
    (pready && !pwrite && hit_ctrl) |-> (prdata[EPI_BIT_ACK] == 1'b0))
    else $error("acknowledge bit read as one");

  // Held asserted level survives acknowledge
  chk_level_hold: assert property (
    (pin_function_enable && detect_mode_select && level_active && wr_ack)
    |=> pin_event_flag)
    else $error("level mode flag cleared while asserted");

  // CPU request tracks flag and enable
  chk_cpu_request: assert property (
    (pin_event_flag && pin_interrupt_enable) |=> cpu_irq)
    else $error("cpu request missing");

  // CPU request absent without enable
  chk_cpu_request_off: assert property (
    !pin_interrupt_enable |=> !cpu_irq)
    else $error("cpu request without enable");

  // Unused control bit reads zero
  chk_unused_zero: assert property (
    (pready && !pwrite && hit_ctrl) |-> (prdata[7] == 1'b0))
    else $error("unused bit read as one");

  // Answer comes one cycle after the access phase opens
  chk_bus_answer: assert property (
    (access && psel && penable) |=> pready)
    else $error("late bus answer");
endmodule // epi_top

/* verif/epi_src.sv */
`timescale 1ns/10ps
// External signal source on the request pin
module epi_src (
  input wire logic pclk,
  input wire logic drive_en,
  input wire logic drive_val,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  output logic pin_level
);
  logic last = 1'b0; // Level seen at the previous edge

  // Remember the wire level for the floating case
  always_ff @(posedge pclk) begin
    last <= pin_level;
  end

  // Driven, pulled, or floating with a changing value
  always_comb begin
    if (drive_en) begin
      pin_level = drive_val;
    end else if (pull_up_en) begin
      pin_level = 1'b1;
    end else if (pull_down_en) begin
      pin_level = 1'b0;
    end else begin
      pin_level = ~last; // Undefined wire, never a steady value
    end
  end
endmodule // epi_src

/* verif/tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the pin interrupt block
module tb;
  import epi_pkg::*;
  logic pclk = 1'b0; // Bus clock
  logic presetn = 1'b0; // Reset, active low
  logic [EPI_AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [EPI_DW-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [EPI_DW-1:0] prdata;
  logic pready, pslverr, pin_in, pin_req_enable, pin_pull_up_en, pin_pull_down_en;
  logic cpu_irq, irq;
  logic drv_en = 1'b1; // Source drives the pin
  logic drv_val = 1'b0; // Level the source drives
  logic [31:0] rdata, v, d, s; // Read data and scratch values
  logic err; // Error response of last transfer
  logic [1:0] m; // Expected mask
  int i, bad_count = 0, check_count = 0;
  integer seed = 32'h563B;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  epi_top epi_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_req_enable(pin_req_enable),
    .pin_pull_up_en(pin_pull_up_en), .pin_pull_down_en(pin_pull_down_en),
    .cpu_irq(cpu_irq), .irq(irq));
  epi_src epi_src_i (.pclk(pclk), .drive_en(drv_en), .drive_val(drv_val),
    .pull_up_en(pin_pull_up_en), .pull_down_en(pin_pull_down_en), .pin_level(pin_in));

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task end_sim();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer, bounded wait for pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= dat;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        end_sim();
      end
      @(posedge pclk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, 4'hF);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Expected pull output for enable, polarity, disable in i[0], i[1], i[2]
  function automatic logic [31:0] pull_exp(input int k, input bit up);
    return {31'h0, k[0] & ~k[2] & (up ? ~k[1] : k[1])};
  endfunction

  // Main sequence
  initial begin
    wt(8);
    presetn <= 1'b1;
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0000);
    check({31'h0, cpu_irq}, 32'h0000_0000);
    // Edges on a disabled pin
    wr(EPI_OFS_CTRL, 32'h0000_0020);
    drv_val <= 1'b1;
    wt(6);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0020);
    // Every pin enable, polarity and pull disable setting
    for (i = 0; i < 8; i++) begin
      v = 32'h0000_0080 | (i << 4);
      wr(EPI_OFS_CTRL, v);
      wt(3);
      rd(EPI_OFS_CTRL);
      check(rdata & 32'hFFFF_FFF7, v & 32'h0000_0077);
      check({31'h0, pin_req_enable}, {31'h0, i[0]});
      check({31'h0, pin_pull_up_en}, pull_exp(i, 1'b1));
      check({31'h0, pin_pull_down_en}, pull_exp(i, 1'b0));
    end
    // Rising edge mode
    wr(EPI_OFS_CTRL, 32'h0000_0032);
    drv_val <= 1'b0;
    wt(6);
    wr(EPI_OFS_CTRL, 32'h0000_0036);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0032);
    drv_val <= 1'b1;
    wt(6);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_003A);
    check({31'h0, cpu_irq}, 32'h0000_0001);
    wr(EPI_OFS_CTRL, 32'h0000_0032);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_003A);
    wr(EPI_OFS_CTRL, 32'h0000_0036);
    wt(2);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0032);
    // Falling edge mode
    wr(EPI_OFS_CTRL, 32'h0000_0016);
    drv_val <= 1'b0;
    wt(6);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_001A);
    wr(EPI_OFS_CTRL, 32'h0000_0016);
    drv_val <= 1'b1;
    wt(6);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0012);
    // High level mode holds the flag against acknowledge
    wr(EPI_OFS_CTRL, 32'h0000_0033);
    wt(4);
    wr(EPI_OFS_CTRL, 32'h0000_0037);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_003B);
    drv_en <= 1'b0;
    wt(6);
    wr(EPI_OFS_CTRL, 32'h0000_0037);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0033);
    // Polling with the request enable off
    wr(EPI_OFS_CTRL, 32'h0000_0031);
    drv_en <= 1'b1;
    wt(6);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0039);
    check({31'h0, cpu_irq}, 32'h0000_0000);
    // Low level mode holds the flag against acknowledge
    wr(EPI_OFS_CTRL, 32'h0000_0011);
    drv_val <= 1'b0;
    wt(6);
    wr(EPI_OFS_CTRL, 32'h0000_0015);
    rd(EPI_OFS_CTRL);
    check(rdata, 32'h0000_0019);
    check({31'h0, pin_pull_up_en}, 32'h0000_0001);
    // Sticky status, mask and interrupt line
    wr(EPI_OFS_CTRL, 32'h0000_0030);
    drv_val <= 1'b0;
    wt(6);
    wr(EPI_OFS_CTRL, 32'h0000_0034);
    rd(EPI_OFS_STAT);
    wr(EPI_OFS_MASK, 32'h0000_0001);
    drv_val <= 1'b1;
    wt(6);
    check({31'h0, irq}, 32'h0000_0001);
    rd(EPI_OFS_STAT);
    check(rdata, 32'h0000_0001);
    wt(3);
    check({31'h0, irq}, 32'h0000_0000);
    wr(EPI_OFS_CTRL, 32'h0000_0034);
    rd(EPI_OFS_STAT);
    check(rdata, 32'h0000_0002);
    // Unmapped address
    wr(8'h0C, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h0000_0001);
    rd(8'h0C);
    check({31'h0, err}, 32'h0000_0001);
    check(rdata, 32'h0000_0000);
    // Random mask writes with random strobes
    m = 2'h1;
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      s = $random(seed);
      apb(1'b1, EPI_OFS_MASK, d, s[3:0]);
      if (s[0]) begin
        m = d[1:0];
      end
      rd(EPI_OFS_MASK);
      check(rdata, {30'h0, m});
    end
    end_sim();
  end
endmodule // tb
